/* File: core/dmc_ctrl.sv */
// controller that drives a 16k x 1 multiplexed-address dram through its pins
// assumes the device data output reaches i_data_out as a plain level, asynchronous to i_clock
//
// Function
// - cell address goes as row half on row strobe, then column half on column strobe.
// - row address steady at row strobe fall, column address steady at column strobe fall.
// - every one of 128 rows must be accessed within each 2 ms.
// - at least eight refresh cycles after power-up before normal use.
// - late column strobe makes read access time depend on column strobe only.
// - write enable must meet early-write setup or both read-write delays.
`timescale 1ns/1ps

module dmc_ctrl (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // user request
  input wire logic i_req_valid,
  input wire dmc_pkg::dmc_req_t i_req,
  output logic o_req_ready,
  // user answer
  output logic o_rsp_valid,
  output logic o_rsp_rdata,
  output logic o_init_done,
  // device pins
  output dmc_pkg::dmc_pins_t o_pins,
  input wire logic i_data_out
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ROW,
    ST_COLSET,
    ST_CAS,
    ST_WEL,
    ST_REF,
    ST_END,
    ST_PRE
  } dmc_state_t;

  dmc_state_t state_q, state_d;
  dmc_pkg::dmc_cnt_t cnt_q, cnt_d;
  dmc_pkg::dmc_cnt_t ras_lo_q, ras_lo_d;
  dmc_pkg::dmc_cnt_t cas_lo_q, cas_lo_d;
  dmc_pkg::dmc_cnt_t ras_hi_q, ras_hi_d;
  dmc_pkg::dmc_pins_t pins_q, pins_d;
  dmc_pkg::dmc_kind_t kind_q, kind_d;
  logic [dmc_pkg::ROW_BITS-1:0] col_q, col_d;
  logic [dmc_pkg::ROW_BITS-1:0] ref_row_q, ref_row_d;
  logic [3:0] init_cnt_q, init_cnt_d;
  logic init_done_q, init_done_d;
  logic ready_q, ready_d;
  logic rsp_valid_q, rsp_valid_d;
  logic rdata_q, rdata_d;
  logic dq1_q, dq2_q;
  logic [7:0] pend_age_q, pend_age_d;
  logic ref_done;
  logic ref_pend;

  // ----------------------------------------------------------------
  // refresh timer
  // ----------------------------------------------------------------
  dmc_refresh_timer #(
    .INTERVAL_CYC(dmc_pkg::REF_INTERVAL_CYC)
  ) u_timer (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_done(ref_done),
    .o_pend(ref_pend)
  );

  // ----------------------------------------------------------------
  // data output synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dq1_q <= 1'h0;
      dq2_q <= 1'h0;
    end else begin
      dq1_q <= i_data_out;
      dq2_q <= dq1_q;
    end
  end

  // ----------------------------------------------------------------
  // strobe sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'h1 : cnt_q;
    pins_d = pins_q;
    kind_d = kind_q;
    col_d = col_q;
    ref_row_d = ref_row_q;
    init_cnt_d = init_cnt_q;
    init_done_d = init_done_q;
    rsp_valid_d = 1'h0;
    rdata_d = rdata_q;
    ref_done = 1'h0;
    case (state_q)
      ST_IDLE: begin
        if (ready_q && i_req_valid) begin
          kind_d = i_req.kind;
          col_d = i_req.addr[dmc_pkg::ROW_BITS-1:0];
          pins_d.mux_address_pins = i_req.addr[dmc_pkg::ADDR_BITS-1:dmc_pkg::ROW_BITS];
          pins_d.write_bit_in = i_req.wdata;
          pins_d.ras_n = 1'h0;
          cnt_d = dmc_pkg::dmc_cnt_t'(dmc_pkg::RAH_CYC - 1);
          state_d = ST_ROW;
        end else if (!init_done_q || ref_pend) begin
          // row-only cycle; rows walk in order so each is visited once per interval round
          pins_d.mux_address_pins = ref_row_q;
          pins_d.ras_n = 1'h0;
          state_d = ST_REF;
        end
      end
      ST_ROW: begin
        if (cnt_q == '0) begin
          pins_d.mux_address_pins = col_q;
          // write enable falls before the column strobe only for an early write
          pins_d.we_n = (kind_q != dmc_pkg::DMC_WRITE);
          state_d = ST_COLSET;
        end
      end
      ST_COLSET: begin
        pins_d.cas_n = 1'h0;
        state_d = ST_CAS;
      end
      ST_CAS: begin
        if (kind_q == dmc_pkg::DMC_WRITE) begin
          if (cas_lo_q >= dmc_pkg::dmc_cnt_t'(dmc_pkg::CAS_CYC)) begin
            pins_d.cas_n = 1'h1;
            pins_d.we_n = 1'h1;
            state_d = ST_END;
          end
        end else if (cas_lo_q == dmc_pkg::dmc_cnt_t'(dmc_pkg::ACC_CYC)) begin
          // sample only from the column strobe, so a long row-to-column gap is harmless
          rsp_valid_d = 1'h1;
          rdata_d = dq2_q;
          if (kind_q == dmc_pkg::DMC_RMW) begin
            pins_d.we_n = 1'h0;
            cnt_d = dmc_pkg::dmc_cnt_t'(dmc_pkg::WE_CYC - 1);
            state_d = ST_WEL;
          end else begin
            pins_d.cas_n = 1'h1;
            state_d = ST_END;
          end
        end
      end
      ST_WEL: begin
        if (cnt_q == '0) begin
          pins_d.cas_n = 1'h1;
          pins_d.we_n = 1'h1;
          state_d = ST_END;
        end
      end
      ST_REF: begin
        ref_done = 1'h1;
        ref_row_d = ref_row_q + 1'h1;
        if (!init_done_q) begin
          init_cnt_d = init_cnt_q + 4'h1;
          init_done_d = (init_cnt_q == 4'(dmc_pkg::INIT_REFRESHES - 1));
        end
        state_d = ST_END;
      end
      ST_END: begin
        if (ras_lo_q >= dmc_pkg::dmc_cnt_t'(dmc_pkg::RAS_CYC)) begin
          pins_d.ras_n = 1'h1;
          cnt_d = dmc_pkg::dmc_cnt_t'(dmc_pkg::RP_CYC - 1);
          state_d = ST_PRE;
        end
      end
      ST_PRE: begin
        if (cnt_q == '0) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_PRE;
      end
    endcase
    // an owed refresh closes the door before the next request
    ready_d = (state_d == ST_IDLE) && init_done_d && !ref_pend;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= ST_PRE;
      cnt_q <= dmc_pkg::dmc_cnt_t'(dmc_pkg::RP_CYC - 1);
      pins_q <= dmc_pkg::PINS_IDLE;
      kind_q <= dmc_pkg::DMC_READ;
      col_q <= '0;
      ref_row_q <= '0;
      init_cnt_q <= 4'h0;
      init_done_q <= 1'h0;
      ready_q <= 1'h0;
      rsp_valid_q <= 1'h0;
      rdata_q <= 1'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      kind_q <= kind_d;
      col_q <= col_d;
      ref_row_q <= ref_row_d;
      init_cnt_q <= init_cnt_d;
      init_done_q <= init_done_d;
      ready_q <= ready_d;
      rsp_valid_q <= rsp_valid_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // strobe and owed-refresh age counters (saturating)
  // ----------------------------------------------------------------
  always_comb begin
    ras_lo_d = pins_q.ras_n ? '0 : ((ras_lo_q == '1) ? ras_lo_q : ras_lo_q + 1'h1);
    cas_lo_d = pins_q.cas_n ? '0 : ((cas_lo_q == '1) ? cas_lo_q : cas_lo_q + 1'h1);
    ras_hi_d = !pins_q.ras_n ? '0 : ((ras_hi_q == '1) ? ras_hi_q : ras_hi_q + 1'h1);
    pend_age_d = !ref_pend ? 8'h00 : ((pend_age_q == 8'hFF) ? pend_age_q : pend_age_q + 8'h01);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ras_lo_q <= '0;
      cas_lo_q <= '0;
      ras_hi_q <= '0;
      pend_age_q <= 8'h00;
    end else begin
      ras_lo_q <= ras_lo_d;
      cas_lo_q <= cas_lo_d;
      ras_hi_q <= ras_hi_d;
      pend_age_q <= pend_age_d;
    end
  end

  assign o_pins = pins_q;
  assign o_req_ready = ready_q;
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_rdata = rdata_q;
  assign o_init_done = init_done_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_ras_fall;
    $fell(pins_q.ras_n);
  endsequence

  sequence s_cas_fall;
    $fell(pins_q.cas_n);
  endsequence

  sequence s_addr_held3;
    $stable(pins_q.mux_address_pins) [*3];
  endsequence

  a_row_addr_hold: assert property (s_ras_fall |=> s_addr_held3)
    else $error("row address moved too soon after row strobe fell");
  a_col_addr_hold: assert property (s_cas_fall |=> $stable(pins_q.mux_address_pins) [*7])
    else $error("column address moved too soon after column strobe fell");
  a_row_before_col: assert property (s_cas_fall |-> !pins_q.ras_n && ras_lo_q > 6'h03)
    else $error("column strobe fell without a held row strobe");
  a_precharge_min: assert property (s_ras_fall |-> ras_hi_q >= 6'h0F)
    else $error("row strobe precharge too short");
  a_ras_pulse_min: assert property ($rose(pins_q.ras_n) |-> $past(ras_lo_q) >= 6'h19 && pins_q.cas_n)
    else $error("row strobe pulse too short or column strobe still low");
  a_early_write_we: assert property ((s_cas_fall and kind_q == dmc_pkg::DMC_WRITE) |-> !pins_q.we_n)
    else $error("early write without write enable low");
  a_read_we_high: assert property ((s_cas_fall and kind_q != dmc_pkg::DMC_WRITE) |-> pins_q.we_n)
    else $error("read cycle with write enable low at column strobe");
  a_late_we_delay: assert property ($fell(pins_q.we_n) && !pins_q.cas_n |->
                                    cas_lo_q >= 6'h0C && ras_lo_q >= 6'h14)
    else $error("late write enable too early after strobes");
  a_read_sample: assert property (rsp_valid_q |-> $past(cas_lo_q) == 6'h13 && !$past(pins_q.cas_n))
    else $error("read bit sampled at wrong time from column strobe");
  a_init_refreshes: assert property ($rose(init_done_q) |-> init_cnt_q == 4'h8 && !ready_q)
    else $error("init done before eight refresh cycles");
  a_refresh_served: assert property (pend_age_q < 8'hC8)
    else $error("owed refresh waited too long");

endmodule // dmc_ctrl

/* File: core/dmc_pkg.sv */
// shared constants and types for the multiplexed-address dram controller
// assumes a single 125 MHz clock; all device timing is derived from it here

package dmc_pkg;

  // ----------------------------------------------------------------
  // clock and geometry
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int ROW_BITS = 7;
  localparam int ADDR_BITS = 14;
  localparam int ROWS = 128;
  localparam int CNT_W = 6;
  localparam int SYNC_STAGES = 2;
  localparam int INIT_REFRESHES = 8;

  // ----------------------------------------------------------------
  // device timing in ns, refresh period in us (slower grade, safe for both)
  // ----------------------------------------------------------------
  localparam int ROW_PRECHARGE_NS = 120;
  localparam int ROW_PULSE_NS = 200;
  localparam int ROW_ADDR_HOLD_NS = 25;
  localparam int COL_PULSE_NS = 135;
  localparam int COLUMN_ACCESS_TIME_NS = 135;
  localparam int WRITE_PULSE_NS = 55;
  localparam int WRITE_TO_COL_LEAD_NS = 70;
  localparam int COLUMN_TO_WRITE_DELAY_NS = 95;
  localparam int ROW_TO_WRITE_DELAY_NS = 160;
  localparam int REFRESH_PERIOD_US = 2000;

  // ----------------------------------------------------------------
  // derived cycle counts: least times round up
  // ----------------------------------------------------------------
  localparam int RP_CYC = (ROW_PRECHARGE_NS * CLK_MHZ + 999) / 1000;
  localparam int RAS_CYC = (ROW_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RAH_CYC = (ROW_ADDR_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CAS_CYC = (COL_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CAC_CYC = (COLUMN_ACCESS_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC = CAC_CYC + SYNC_STAGES;
  localparam int WP_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CWL_CYC = (WRITE_TO_COL_LEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_CYC = (WP_CYC > CWL_CYC) ? WP_CYC : CWL_CYC;
  localparam int CWD_CYC = (COLUMN_TO_WRITE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int RWD_CYC = (ROW_TO_WRITE_DELAY_NS * CLK_MHZ + 999) / 1000;
  // longest time rounds down: one row every period / rows
  localparam int REF_INTERVAL_CYC = (REFRESH_PERIOD_US * CLK_MHZ) / ROWS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [CNT_W-1:0] dmc_cnt_t;

  typedef enum logic [1:0] {
    DMC_READ,
    DMC_WRITE,
    DMC_RMW
  } dmc_kind_t;

  typedef struct packed {
    dmc_kind_t kind;
    logic [ADDR_BITS-1:0] addr;
    logic wdata;
  } dmc_req_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [ROW_BITS-1:0] mux_address_pins;
    logic write_bit_in;
  } dmc_pins_t;

  localparam dmc_pins_t PINS_IDLE = '{ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1,
                                     mux_address_pins: '0, write_bit_in: 1'h0};

endpackage

/* File: core/dmc_refresh_timer.sv */
// refresh interval timer with a small count of owed refreshes
// assumes i_done is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps

module dmc_refresh_timer #(
  parameter int INTERVAL_CYC = dmc_pkg::REF_INTERVAL_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // refresh handshake
  input wire logic i_done,
  output logic o_pend
);

  localparam int TW = $clog2(INTERVAL_CYC);

  logic [TW-1:0] tmr_q, tmr_d;
  logic [1:0] pend_q, pend_d;
  logic tick;

  // ----------------------------------------------------------------
  // interval count
  // ----------------------------------------------------------------
  always_comb begin
    tick = (tmr_q == TW'(INTERVAL_CYC - 1));
    tmr_d = tick ? '0 : tmr_q + 1'h1;
    pend_d = pend_q;
    // a tick in the same cycle as a done leaves the count unchanged, so no tick is lost
    if (tick && !i_done && pend_q != 2'h3) begin
      pend_d = pend_q + 2'h1;
    end else if (!tick && i_done && pend_q != 2'h0) begin
      pend_d = pend_q - 2'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tmr_q <= '0;
      pend_q <= 2'h0;
    end else begin
      tmr_q <= tmr_d;
      pend_q <= pend_d;
    end
  end

  assign o_pend = (pend_q != 2'h0);

endmodule // dmc_refresh_timer

/* File: tb/dmc_dram_model.sv */
// behavioural model of the 16k x 1 multiplexed-address dram on the far side of dmc_ctrl
// assumes pins change only at clock edges; counts controller timing faults in o_viol
`timescale 1ns/1ps

module dmc_dram_model #(
  parameter int ACCESS_NS = 135,
  parameter int PRECHARGE_NS = 120,
  parameter int CWD_NS = 95,
  parameter int RWD_NS = 160
) (
  // device pins
  input wire dmc_pkg::dmc_pins_t i_pins,
  output logic o_data_out,
  // observation
  output logic o_drive,
  output logic [15:0] o_viol,
  output logic [15:0] o_ras_falls,
  output logic [15:0] o_refreshes
);
  logic cell_q [0:16383];
  logic [6:0] row_q;
  logic [6:0] col_q;
  logic [6:0] last_ref_q;
  logic in_row_q;
  logic col_seen_q;
  realtime t_ras;
  realtime t_cas;
  realtime t_rise;

  initial begin
    o_data_out = 1'h0;
    o_drive = 1'h0;
    o_viol = 16'h0;
    o_ras_falls = 16'h0;
    o_refreshes = 16'h0;
    last_ref_q = 7'h7F;
    in_row_q = 1'h0;
    col_seen_q = 1'h0;
    t_rise = -1000.0;
    t_ras = 0.0;
    t_cas = 0.0;
    for (int i = 0; i < 16384; i++) cell_q[i] = 1'h0;
  end

  // ----------------------------------------------------------------
  // row strobe
  // ----------------------------------------------------------------
  always @(negedge i_pins.ras_n) begin
    if ($realtime - t_rise < PRECHARGE_NS) o_viol = o_viol + 16'h1;
    row_q = i_pins.mux_address_pins;
    t_ras = $realtime;
    in_row_q = 1'h1;
    col_seen_q = 1'h0;
    o_ras_falls = o_ras_falls + 16'h1;
    #4;
    if (i_pins.mux_address_pins !== row_q) o_viol = o_viol + 16'h1;
  end

  // row-only cycles must walk the rows in order so each is seen once per period
  always @(posedge i_pins.ras_n) begin
    if (in_row_q) begin
      t_rise = $realtime;
      in_row_q = 1'h0;
      if (!col_seen_q) begin
        if (row_q !== last_ref_q + 7'h01) o_viol = o_viol + 16'h1;
        last_ref_q = row_q;
        o_refreshes = o_refreshes + 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // column strobe and data paths
  // ----------------------------------------------------------------
  always @(negedge i_pins.cas_n) begin : col_blk
    logic early;
    col_q = i_pins.mux_address_pins;
    t_cas = $realtime;
    col_seen_q = 1'h1;
    early = (i_pins.we_n === 1'h0);
    if (early) cell_q[{row_q, col_q}] = i_pins.write_bit_in;
    #4;
    if (i_pins.mux_address_pins !== col_q) o_viol = o_viol + 16'h1;
    #(ACCESS_NS - 4);
    if (!early && i_pins.cas_n === 1'h0) begin
      o_data_out = cell_q[{row_q, col_q}];
      o_drive = 1'h1;
    end
  end

  always @(negedge i_pins.we_n) begin
    if (i_pins.cas_n === 1'h0 && col_seen_q) begin
      if ($realtime - t_cas < CWD_NS || $realtime - t_ras < RWD_NS) o_viol = o_viol + 16'h1;
      cell_q[{row_q, col_q}] = i_pins.write_bit_in;
    end
  end

  // released output shows the inverse so a stale sample cannot pass
  always @(posedge i_pins.cas_n) begin
    if (o_drive) begin
      o_drive = 1'h0;
      o_data_out = ~o_data_out;
    end
  end
endmodule // dmc_dram_model

/* File: tb/test_dmc_ctrl.sv */
// self-checking bench for dmc_ctrl against the behavioural dram model
// assumes the default refresh interval of the package
`timescale 1ns/1ps

module test_dmc_ctrl;
  logic i_clock = 1'h0;
  logic i_rst = 1'h1;
  logic i_req_valid = 1'h0;
  dmc_pkg::dmc_req_t i_req = '0;
  logic o_req_ready;
  logic o_rsp_valid;
  logic o_rsp_rdata;
  logic o_init_done;
  dmc_pkg::dmc_pins_t o_pins;
  logic data_out;
  logic drive;
  logic [15:0] viol;
  logic [15:0] ras_falls;
  logic [15:0] refreshes;
  int fails = 0;
  int compares = 0;

  always #4 i_clock = ~i_clock;

  dmc_ctrl dmc_ctrl_i (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_req_valid(i_req_valid),
    .i_req(i_req),
    .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid),
    .o_rsp_rdata(o_rsp_rdata),
    .o_init_done(o_init_done),
    .o_pins(o_pins),
    .i_data_out(data_out)
  );

  dmc_dram_model dmc_dram_model_i (
    .i_pins(o_pins),
    .o_data_out(data_out),
    .o_drive(drive),
    .o_viol(viol),
    .o_ras_falls(ras_falls),
    .o_refreshes(refreshes)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // request is held until ready is seen, so a refused request is simply retried
  task automatic issue(input dmc_pkg::dmc_kind_t kind, input logic [13:0] addr, input logic wdata);
    int n;
    @(posedge i_clock);
    #1;
    i_req_valid = 1'h1;
    i_req = '{kind: kind, addr: addr, wdata: wdata};
    n = 0;
    while (o_req_ready !== 1'h1 && n < 2500) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    if (n == 2500) fails++;
    @(posedge i_clock);
    #1;
    i_req_valid = 1'h0;
  endtask

  task automatic access(input dmc_pkg::dmc_kind_t kind, input logic [13:0] addr, input logic wdata,
                        output logic rbit);
    int n;
    issue(kind, addr, wdata);
    n = 0;
    while (o_rsp_valid !== 1'h1 && n < 100) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    if (n == 100) fails++;
    rbit = o_rsp_rdata;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_init();
    int n;
    n = 0;
    while (o_req_ready !== 1'h1 && n < 1000) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    chk(o_init_done, 16'h1);
    chk(refreshes, 16'h8);
    chk(ras_falls >= 16'h8, 16'h1);
    $display("test init done");
  endtask

  // corners of row and column halves, written then read, in both polarities
  task automatic t_write_read();
    logic [13:0] addrs [4];
    logic rbit;
    addrs = '{14'h0000, 14'h007F, 14'h3F80, 14'h3FFF};
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) issue(dmc_pkg::DMC_WRITE, addrs[i], 1'(i + p) ^ 1'h1);
      for (int i = 0; i < 4; i++) begin
        access(dmc_pkg::DMC_READ, addrs[i], 1'(i + p), rbit);
        chk(rbit, 16'((i + p) % 2 == 0));
      end
    end
    $display("test write_read done");
  endtask

  task automatic t_rmw();
    logic rbit;
    issue(dmc_pkg::DMC_WRITE, 14'h1555, 1'h1);
    issue(dmc_pkg::DMC_WRITE, 14'h2AAA, 1'h0);
    access(dmc_pkg::DMC_RMW, 14'h1555, 1'h0, rbit);
    chk(rbit, 16'h1);
    access(dmc_pkg::DMC_RMW, 14'h2AAA, 1'h1, rbit);
    chk(rbit, 16'h0);
    access(dmc_pkg::DMC_READ, 14'h1555, 1'h1, rbit);
    chk(rbit, 16'h0);
    access(dmc_pkg::DMC_READ, 14'h2AAA, 1'h0, rbit);
    chk(rbit, 16'h1);
    chk(drive, 16'h0);
    $display("test rmw done");
  endtask

  // an idle window of whole intervals must hold exactly that many row-only cycles
  task automatic t_refresh();
    logic [15:0] r0;
    repeat (3000) @(posedge i_clock);
    r0 = refreshes;
    repeat (10 * dmc_pkg::REF_INTERVAL_CYC) @(posedge i_clock);
    chk(refreshes - r0, 16'hA);
    chk(viol, 16'h0);
    $display("test refresh done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_clock);
    #1;
    i_rst = 1'h0;
    t_init();
    t_write_read();
    t_rmw();
    t_refresh();
    end_sim();
  end

  initial begin
    #(40000 * 8);
    fails++;
    end_sim();
  end
endmodule // test_dmc_ctrl
